// >>> rtl/acl_defines.vh
/*
 Constants shared by the accumulator subtract/logic/compare slice.
 Assumes inclusion by bare name from the rtl folder; holds definitions only.
*/
`ifndef ACL_DEFINES_VH
`define ACL_DEFINES_VH

// Opcode layout: [7:6] group, [5:3] operation, [2:0] register_code
`define ACL_GRP_REG 2'h2
`define ACL_GRP_IMM 2'h3
`define ACL_RC_MEM 3'h6
`define ACL_RC_ACC 3'h7
`define ACL_RC_H 3'h4
`define ACL_RC_L 3'h5
`define ACL_PFX_X 8'hDD
`define ACL_PFX_Y 8'hFD

// Operation field codes
`define ACL_OP_SUB 3'h2
`define ACL_OP_SBC 3'h3
`define ACL_OP_AND 3'h4
`define ACL_OP_OR 3'h5
`define ACL_OP_XOR 3'h6
`define ACL_OP_CP 3'h7

// Flag bit positions
`define ACL_F_S 7
`define ACL_F_Z 6
`define ACL_F_H 4
`define ACL_F_PV 2
`define ACL_F_N 1
`define ACL_F_C 0

// Clock states per machine cycle, one clock state per core_clk cycle
`define ACL_T_FETCH 3'h4
`define ACL_T_READ 3'h3
`define ACL_T_ADDR 3'h5

// Reset values
`define ACL_RST_REG 8'h00
`define ACL_RST_FLAGS 8'h00
`define ACL_RST_WORD 16'h0000

`endif

// >>> rtl/acl_alu_core.v
/*
 Combinational result and flag generator for subtract, subtract with borrow,
 AND, OR, exclusive-OR and compare. Assumes the caller registers the outputs.
*/
`timescale 1ns/10ps
`default_nettype none
`include "acl_defines.vh"

module acl_alu_core(
	input wire [2:0] op_sel,
	input wire [7:0] a,
	input wire [7:0] b,
	input wire cin,
	output reg [7:0] result,
	output reg [7:0] flags_out,
	output reg acc_we
);

	reg borrow_in;
	reg [8:0] diff;
	reg [4:0] half;
	reg ovf;

	function parity_even;
		input [7:0] v;
		begin
			parity_even = ~^v;
		end
	endfunction

	always @*
	begin
		borrow_in = (op_sel == `ACL_OP_SBC) & cin;
		diff = {1'b0, a} - {1'b0, b} - {8'h00, borrow_in};
		half = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, borrow_in};
		ovf = (a[7] != b[7]) && (diff[7] != a[7]);
		result = a;
		flags_out = `ACL_RST_FLAGS;
		acc_we = 1'b1;
		case (op_sel)
			`ACL_OP_SUB, `ACL_OP_SBC, `ACL_OP_CP:
			begin
				result = diff[7:0];
				flags_out[`ACL_F_H] = half[4];
				flags_out[`ACL_F_PV] = ovf;
				flags_out[`ACL_F_N] = 1'b1;
				flags_out[`ACL_F_C] = diff[8];
				acc_we = (op_sel != `ACL_OP_CP);
			end
			`ACL_OP_AND:
			begin
				result = a & b;
				flags_out[`ACL_F_H] = 1'b1;
				flags_out[`ACL_F_PV] = parity_even(a & b);
			end
			`ACL_OP_OR:
			begin
				result = a | b;
				flags_out[`ACL_F_PV] = parity_even(a | b);
			end
			`ACL_OP_XOR:
			begin
				result = a ^ b;
				flags_out[`ACL_F_PV] = parity_even(a ^ b);
			end
			default:
			begin
				acc_we = 1'b0;
			end
		endcase
		// Sign is bit 7; zero on compare means operand equals accumulator
		flags_out[`ACL_F_S] = result[7];
		flags_out[`ACL_F_Z] = (result == 8'h00);
		if (op_sel == `ACL_OP_CP)
		begin
			flags_out[`ACL_F_Z] = (a == b);
		end
	end

endmodule

`default_nettype wire

// >>> rtl/acl_alu.v
/*
 Accumulator slice that fetches and executes the subtract, subtract with
 borrow, AND, OR, exclusive-OR and compare group from memory.
 Assumes a synchronous memory on core_clk that holds mem_rdata valid on the
 last clock state of every read machine cycle, and host writes while idle.
*/
`timescale 1ns/10ps
`default_nettype none
`include "acl_defines.vh"

module acl_alu(
	input wire core_clk,
	input wire rst_b,
	input wire run,
	input wire pc_load,
	input wire [15:0] pc_load_value,
	input wire reg_wr_en,
	input wire [2:0] reg_wr_sel,
	input wire [7:0] reg_wr_data,
	input wire idx_x_wr_en,
	input wire idx_y_wr_en,
	input wire [15:0] idx_wr_data,
	input wire flag_wr_en,
	input wire [7:0] flag_wr_data,
	input wire [2:0] reg_rd_sel,
	output wire [7:0] reg_rd_data,
	output wire [7:0] acc,
	output reg [7:0] flags,
	output reg [15:0] pc,
	output reg [15:0] index_pair_x,
	output reg [15:0] index_pair_y,
	output reg [15:0] mem_addr,
	output reg mem_rd,
	input wire [7:0] mem_rdata,
	output wire busy,
	output reg instr_done,
	output reg illegal_op
);

	localparam [2:0] ST_IDLE = 3'h0;
	localparam [2:0] ST_FETCH = 3'h1;
	localparam [2:0] ST_FETCH2 = 3'h2;
	localparam [2:0] ST_IMM = 3'h3;
	localparam [2:0] ST_ADDR = 3'h4;
	localparam [2:0] ST_MEM = 3'h5;

	reg [7:0] gpr [0:7];
	reg [2:0] state;
	reg [2:0] tcnt;
	reg [7:0] op;
	reg [7:0] disp;
	reg indexed;
	reg use_y;
	reg [2:0] next_state;
	reg [2:0] next_tcnt;
	reg [15:0] next_addr;
	reg next_rd;
	reg [15:0] next_pc;
	reg [7:0] next_op;
	reg [7:0] next_disp;
	reg next_indexed;
	reg next_use_y;
	reg exec_en;
	reg bad;
	reg go_next;
	reg [15:0] pc_inc;
	reg [7:0] cur_op;
	reg [7:0] exec_b;
	wire [15:0] pointer_pair;
	wire [15:0] index_base;
	wire [15:0] eff_addr;
	wire [7:0] alu_res;
	wire [7:0] alu_flags;
	wire alu_acc_we;
	integer i;

	// Only the operation codes of this slice; add and add-with-carry belong elsewhere
	function in_group;
		input [7:0] v;
		in_group = v[5] | v[4];
	endfunction
	// Register form with a real register, not the memory code
	function is_reg_form;
		input [7:0] v;
		is_reg_form = (v[7:6] == `ACL_GRP_REG) && (v[2:0] != `ACL_RC_MEM);
	endfunction
	// Memory form through a pointer: the only form allowed after a prefix
	function is_ptr_form;
		input [7:0] v;
		is_ptr_form = (v[7:6] == `ACL_GRP_REG) && (v[2:0] == `ACL_RC_MEM);
	endfunction

	assign pointer_pair = {gpr[`ACL_RC_H], gpr[`ACL_RC_L]};
	assign index_base = use_y ? index_pair_y : index_pair_x;
	assign eff_addr = index_base + {{8{disp[7]}}, disp};
	assign acc = gpr[`ACL_RC_ACC];
	assign reg_rd_data = gpr[reg_rd_sel];
	assign busy = (state != ST_IDLE);

	acl_alu_core u_core(
		.op_sel(cur_op[5:3]),
		.a(gpr[`ACL_RC_ACC]),
		.b(exec_b),
		.cin(flags[`ACL_F_C]),
		.result(alu_res),
		.flags_out(alu_flags),
		.acc_we(alu_acc_we)
	);

	always @*
	begin
		cur_op = (state == ST_FETCH) ? mem_rdata : op;
		// Register form reads the file; every other form uses the byte just read
		exec_b = (state == ST_FETCH) ? gpr[mem_rdata[2:0]] : mem_rdata;
		next_state = state;
		next_tcnt = tcnt - 3'h1;
		next_addr = mem_addr;
		next_rd = mem_rd;
		next_pc = pc;
		next_op = op;
		next_disp = disp;
		next_indexed = indexed;
		next_use_y = use_y;
		exec_en = 1'b0;
		bad = 1'b0;
		go_next = 1'b0;
		pc_inc = pc + 16'h0001;
		if (state == ST_IDLE)
		begin
			next_tcnt = tcnt;
			if (run)
			begin
				next_state = ST_FETCH;
				next_tcnt = `ACL_T_FETCH;
				next_addr = pc;
				next_rd = 1'b1;
			end
		end
		else if (tcnt == 3'h1)
		begin
			case (state)
				ST_FETCH:
				begin
					next_pc = pc_inc;
					next_op = mem_rdata;
					next_indexed = 1'b0;
					if ((mem_rdata == `ACL_PFX_X) || (mem_rdata == `ACL_PFX_Y))
					begin
						next_indexed = 1'b1;
						next_use_y = (mem_rdata == `ACL_PFX_Y);
						next_state = ST_FETCH2;
						next_tcnt = `ACL_T_FETCH;
						next_addr = pc_inc;
					end
					else if (!in_group(mem_rdata))
					begin
						bad = 1'b1;
						go_next = 1'b1;
					end
					else if (is_reg_form(mem_rdata))
					begin
						exec_en = 1'b1;
						go_next = 1'b1;
					end
					else if (is_ptr_form(mem_rdata))
					begin
						next_state = ST_MEM;
						next_tcnt = `ACL_T_READ;
						next_addr = pointer_pair;
					end
					else if ((mem_rdata[7:6] == `ACL_GRP_IMM) && (mem_rdata[2:0] == `ACL_RC_MEM))
					begin
						next_state = ST_IMM;
						next_tcnt = `ACL_T_READ;
						next_addr = pc_inc;
					end
					else
					begin
						bad = 1'b1;
						go_next = 1'b1;
					end
				end
				ST_FETCH2:
				begin
					next_pc = pc_inc;
					next_op = mem_rdata;
					if (is_ptr_form(mem_rdata) && in_group(mem_rdata))
					begin
						next_state = ST_IMM;
						next_tcnt = `ACL_T_READ;
						next_addr = pc_inc;
					end
					else
					begin
						bad = 1'b1;
						go_next = 1'b1;
					end
				end
				ST_IMM:
				begin
					next_pc = pc_inc;
					if (indexed)
					begin
						next_disp = mem_rdata;
						next_state = ST_ADDR;
						next_tcnt = `ACL_T_ADDR;
						next_rd = 1'b0;
					end
					else
					begin
						exec_en = 1'b1;
						go_next = 1'b1;
					end
				end
				ST_ADDR:
				begin
					next_state = ST_MEM;
					next_tcnt = `ACL_T_READ;
					next_addr = eff_addr;
					next_rd = 1'b1;
				end
				ST_MEM:
				begin
					exec_en = 1'b1;
					go_next = 1'b1;
				end
				default:
				begin
					next_state = ST_IDLE;
					next_rd = 1'b0;
				end
			endcase
			// Stopping is honoured only between instructions
			if (go_next)
			begin
				next_indexed = 1'b0;
				if (run)
				begin
					next_state = ST_FETCH;
					next_tcnt = `ACL_T_FETCH;
					next_addr = next_pc;
					next_rd = 1'b1;
				end
				else
				begin
					next_state = ST_IDLE;
					next_rd = 1'b0;
				end
			end
		end
	end

	always @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			for (i = 0; i < 8; i = i + 1)
				gpr[i] <= `ACL_RST_REG;
			flags <= `ACL_RST_FLAGS;
			pc <= `ACL_RST_WORD;
			index_pair_x <= `ACL_RST_WORD;
			index_pair_y <= `ACL_RST_WORD;
			mem_addr <= `ACL_RST_WORD;
			mem_rd <= 1'b0;
			state <= ST_IDLE;
			tcnt <= 3'h0;
			op <= `ACL_RST_REG;
			disp <= `ACL_RST_REG;
			indexed <= 1'b0;
			use_y <= 1'b0;
			instr_done <= 1'b0;
			illegal_op <= 1'b0;
		end
		else
		begin
			state <= next_state;
			tcnt <= next_tcnt;
			mem_addr <= next_addr;
			mem_rd <= next_rd;
			op <= next_op;
			disp <= next_disp;
			indexed <= next_indexed;
			use_y <= next_use_y;
			instr_done <= exec_en;
			illegal_op <= bad;
			pc <= next_pc;
			if (exec_en)
			begin
				flags <= alu_flags;
				if (alu_acc_we)
					gpr[`ACL_RC_ACC] <= alu_res;
			end
			// Host loads are taken only while idle so they never race execution
			if (state == ST_IDLE)
			begin
				if (pc_load)
					pc <= pc_load_value;
				if (reg_wr_en && (reg_wr_sel != `ACL_RC_MEM))
					gpr[reg_wr_sel] <= reg_wr_data;
				if (flag_wr_en)
					flags <= flag_wr_data;
				if (idx_x_wr_en)
					index_pair_x <= idx_wr_data;
				if (idx_y_wr_en)
					index_pair_y <= idx_wr_data;
			end
		end
	end

endmodule

`default_nettype wire

// >>> tb/acl_alu_props.sv
/*
 Port checker for the accumulator subtract/logic/compare slice.
 Assumes it is bound onto acl_alu, with a single clock domain.
*/
`timescale 1ns/10ps
`default_nettype none
module acl_alu_props(
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic reg_wr_en,
	input wire logic flag_wr_en,
	input wire logic busy,
	input wire logic mem_rd,
	input wire logic instr_done,
	input wire logic illegal_op,
	input wire logic [7:0] acc,
	input wire logic [7:0] flags
);
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (!rst_b);
	// Indexed forms: five states without a read, then the operand read
	sequence addr_then_read;
		!mem_rd [*5] ##1 mem_rd [*3];
	endsequence
	chk_read_len: assert property ($rose(mem_rd) |-> mem_rd [*3])
		else $error("read cycle too short");
	chk_addr_cycle: assert property ($fell(mem_rd) && busy |-> addr_then_read)
		else $error("address cycle length wrong");
	chk_end_bound: assert property ($rose(busy) |-> ##[4:19] (instr_done || illegal_op))
		else $error("instruction not ended in time");
	chk_sign_bit: assert property (instr_done && $changed(acc) |-> flags[7] == acc[7])
		else $error("sign flag differs from bit 7");
	chk_zero_flag: assert property (instr_done && $changed(acc) |-> flags[6] == (acc == 8'h00))
		else $error("zero flag differs from result");
	chk_logic_carry: assert property (instr_done && !flags[1] |-> !flags[0])
		else $error("carry left set by logic op");
	chk_acc_cause: assert property ($changed(acc) |-> instr_done || $past(reg_wr_en))
		else $error("accumulator changed without cause");
	chk_flag_cause: assert property ($changed(flags) |-> instr_done || $past(flag_wr_en))
		else $error("flags changed without cause");
endmodule
bind acl_alu acl_alu_props u_props(.core_clk(core_clk), .rst_b(rst_b), .reg_wr_en(reg_wr_en),
	.flag_wr_en(flag_wr_en), .busy(busy), .mem_rd(mem_rd), .instr_done(instr_done),
	.illegal_op(illegal_op), .acc(acc), .flags(flags));
`default_nettype wire

// >>> tb/acl_mem_model.sv
/*
 System memory on the processor bus, read only, no wait states.
 Assumes the bench fills it by hierarchy while the slice is idle.
*/
`timescale 1ns/10ps
`default_nettype none
module acl_mem_model(
	input wire logic [15:0] mem_addr,
	input wire logic mem_rd,
	output logic [7:0] mem_rdata
);
	logic [7:0] mem [0:65535];
	// Released bus shows inverted data, so a late sample cannot pass
	assign mem_rdata = mem_rd ? mem[mem_addr] : ~mem[mem_addr];
endmodule
`default_nettype wire

// >>> tb/acl_alu_test.sv
/*
 Self-checking bench for acl_alu over every operation and operand form.
 Assumes acl_mem_model as program and data memory.
*/
`timescale 1ns/10ps
`default_nettype none
module acl_alu_test;
	logic core_clk = '0, rst_b = '0, run = '0, pc_load = '0, reg_wr_en = '0;
	logic idx_x_wr_en = '0, idx_y_wr_en = '0, flag_wr_en = '0;
	logic [15:0] pc_load_value = '0, idx_wr_data = '0, pc, mem_addr;
	logic [2:0] reg_wr_sel = '0, reg_rd_sel = '0;
	logic [7:0] reg_wr_data = '0, flag_wr_data = '0, mem_rdata, acc, flags, b0, opd, reg_rd_data;
	logic [15:0] index_pair_x, index_pair_y;
	logic mem_rd, busy, instr_done, illegal_op;
	integer n_fail = 0, n_compared = 0, i, j, k;
	localparam [47:0] REGV = 48'h017F80FF2040;
	localparam [39:0] OPD = 40'h80805D3300;
	localparam [39:0] CYC = 40'h1313070704;
	localparam [39:0] NPB = 40'h0303010201;
	always #5 core_clk = ~core_clk;
	acl_alu u_dut(.core_clk(core_clk), .rst_b(rst_b), .run(run), .pc_load(pc_load),
		.pc_load_value(pc_load_value), .reg_wr_en(reg_wr_en), .reg_wr_sel(reg_wr_sel),
		.reg_wr_data(reg_wr_data), .idx_x_wr_en(idx_x_wr_en), .idx_y_wr_en(idx_y_wr_en),
		.idx_wr_data(idx_wr_data), .flag_wr_en(flag_wr_en), .flag_wr_data(flag_wr_data),
		.reg_rd_sel(reg_rd_sel), .reg_rd_data(reg_rd_data), .acc(acc), .flags(flags), .pc(pc),
		.index_pair_x(index_pair_x), .index_pair_y(index_pair_y), .mem_addr(mem_addr),
		.mem_rd(mem_rd),
		.mem_rdata(mem_rdata), .busy(busy), .instr_done(instr_done), .illegal_op(illegal_op));
	acl_mem_model u_mem(.mem_addr(mem_addr), .mem_rd(mem_rd), .mem_rdata(mem_rdata));
	function [15:0] ref_op(input [2:0] op, input [7:0] a, b, input c);
		logic [8:0] d;
		logic [4:0] h;
		logic [7:0] r;
		begin
			d = {1'b0, a} - {1'b0, b} - (op == 3'h3 && c);
			h = {1'b0, a[3:0]} - {1'b0, b[3:0]} - (op == 3'h3 && c);
			r = op == 3'h4 ? a & b : op == 3'h5 ? a | b : op == 3'h6 ? a ^ b : d[7:0];
			if (op > 3'h3 && op < 3'h7)
				ref_op = {r[7], r == 8'h00, 1'b0, op == 3'h4, 1'b0, ~^r, 2'h0, r};
			else
				ref_op = {r[7], r == 8'h00, 1'b0, h[4], 1'b0, (a[7] ^ b[7]) & (a[7] ^ r[7]),
					1'b1, d[8], op == 3'h7 ? a : r};
		end
	endfunction
	task complete_run;
		$display("Compared %0d, failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task check(input [31:0] got, exp);
		n_compared++;
		if (got !== exp)
		begin
			n_fail++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Kinds: 0 register, 1 flags, 2 pc, 3 and 4 index pairs; only while idle
	task host(input [2:0] kind, sel, input [15:0] v);
		@(posedge core_clk);
		{idx_y_wr_en, idx_x_wr_en, pc_load, flag_wr_en, reg_wr_en} <= 5'h01 << kind;
		reg_wr_sel <= sel;
		reg_wr_data <= v[7:0];
		flag_wr_data <= v[7:0];
		pc_load_value <= v;
		idx_wr_data <= v;
		@(posedge core_clk);
		{idx_y_wr_en, idx_x_wr_en, pc_load, flag_wr_en, reg_wr_en} <= 5'h00;
	endtask
	// One instruction at 0100 with carry set beforehand; run held for a single edge
	task exec(input [7:0] c0, c1, c2, a, input [16:0] exp, input integer cyc, np);
		u_mem.mem[16'h0100] = c0;
		u_mem.mem[16'h0101] = c1;
		u_mem.mem[16'h0102] = c2;
		host(2, 0, 16'h0100);
		host(0, 7, {8'h00, a});
		host(1, 0, 16'h0001);
		@(posedge core_clk);
		run <= 1'b1;
		@(posedge core_clk);
		run <= 1'b0;
		k = 0;
		while (!(instr_done === 1'b1 || illegal_op === 1'b1) && k < 40)
		begin
			@(posedge core_clk);
			k++;
			#1;
		end
		if (k == 40)
		begin
			n_fail++;
			complete_run;
		end
		check({illegal_op, flags, acc}, exp);
		check(k, cyc);
		check(pc, 16'h0100 + np);
	endtask
	initial
	begin
		repeat (5) @(posedge core_clk);
		rst_b <= 1'b1;
		for (i = 0; i < 6; i++)
			host(0, i, {8'h00, REGV[47 - 8 * i -: 8]});
		host(3, 0, 16'h3000);
		host(4, 0, 16'h1000);
		// Code 110 names no register, so this load must be ignored
		host(0, 6, 16'h00AA);
		for (i = 0; i < 7; i++)
		begin
			@(posedge core_clk);
			reg_rd_sel <= i[2:0];
			@(posedge core_clk);
			#1;
			check(reg_rd_data, i == 6 ? 8'h00 : REGV[47 - 8 * i -: 8]);
		end
		check({index_pair_x, index_pair_y}, 32'h30001000);
		u_mem.mem[16'h2040] = 8'h5D;
		u_mem.mem[16'h2FFE] = 8'h80;
		u_mem.mem[16'h1005] = 8'h80;
		for (i = 2; i < 8; i++)
			for (j = 0; j < 5; j++)
			begin
				opd = j ? OPD[8 * j +: 8] : REGV[47 - 8 * (i - 2) -: 8];
				b0 = j == 0 ? {2'h2, i[2:0], i[2:0] - 3'h2} : j == 1 ? {2'h3, i[2:0], 3'h6} :
					j == 2 ? {2'h2, i[2:0], 3'h6} : j == 3 ? 8'hDD : 8'hFD;
				exec(b0, j == 1 ? 8'h33 : {2'h2, i[2:0], 3'h6}, j == 3 ? 8'hFE : 8'h05,
					j == 4 ? 8'h80 : 8'h96, {1'b0, ref_op(i[2:0], j == 4 ? 8'h80 : 8'h96, opd,
					1'b1)}, CYC[8 * j +: 8], NPB[8 * j +: 8]);
			end
		exec(8'h97, 8'h00, 8'h00, 8'h96, {1'b0, 8'h42, 8'h00}, 4, 1);
		exec(8'h80, 8'h00, 8'h00, 8'h96, {1'b1, 8'h01, 8'h96}, 4, 1);
		exec(8'hDD, 8'h90, 8'h00, 8'h96, {1'b1, 8'h01, 8'h96}, 8, 2);
		exec(8'h16, 8'h00, 8'h00, 8'h96, {1'b1, 8'h01, 8'h96}, 4, 1);
		complete_run;
	end
endmodule
`default_nettype wire
